// *** ofs_consts.svh ***
`ifndef OFS_CONSTS_SVH
`define OFS_CONSTS_SVH

// ---------------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------------
`define OFS_ADDR_STATUS_FIRST   8'h00
`define OFS_ADDR_STATUS_SECOND  8'h01
`define OFS_ADDR_STATUS_LED     8'h02
`define OFS_ADDR_WRITE_INDEX    8'h04
`define OFS_ADDR_READ_INDEX     8'h05
`define OFS_ADDR_COUNT_LOSS     8'h06
`define OFS_ADDR_COUNT_LOW      8'h07

// ---------------------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------------------
`define OFS_S1_EXP_BIT          3
`define OFS_S1_LIMB_BIT         2
`define OFS_S1_LIMA_BIT         1
`define OFS_S1_PWR_BIT          0
`define OFS_S2_LED9_BIT         7
`define OFS_S2_OOR_BIT          6
`define OFS_S2_INV_BIT          2
`define OFS_LED9_IDX            8
`define OFS_RESET_BYTE          8'h00
`define OFS_RESET_PWR           1'b1

// ---------------------------------------------------------------------------
// conversion range limits (20-bit two's complement)
// ---------------------------------------------------------------------------
`define OFS_ADC_W               20
`define OFS_ADC_POS_FULL        20'h7FFFF
`define OFS_ADC_NEG_QUARTER     20'hE0000

// ---------------------------------------------------------------------------
// fifo widths and limits
// ---------------------------------------------------------------------------
`define OFS_IDX_W               8
`define OFS_CNT_W               9
`define OFS_LOST_W              7
`define OFS_LOST_MAX            7'h7F
`define OFS_FIFO_FULL           9'h100

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define OFS_CLK_KHZ             200000
`define OFS_OOR_DELAY_MS        10
`define OFS_OOR_CNT_W           21

`endif

// *** ofs_pkg.sv ***
`default_nettype none
`include "ofs_consts.svh"
package ofs_pkg;

  // fifo index and counter state
  typedef struct packed {
    logic [`OFS_IDX_W-1:0]  wr_idx;
    logic [`OFS_IDX_W-1:0]  rd_idx;
    logic [`OFS_CNT_W-1:0]  fill;
    logic [`OFS_LOST_W-1:0] lost;
  } ofs_fifo_st_t;

  // status flag and read-port state
  typedef struct packed {
    logic                     exposure_overflow_flag;
    logic                     lim_a;
    logic                     lim_b;
    logic                     pwr;
    logic [8:0]               led_low;
    logic                     oor;
    logic                     inv_cfg;
    logic [`OFS_OOR_CNT_W-1:0] oor_cnt;
    logic [7:0]               rdata;
    logic                     irq_a;
    logic                     irq_b;
  } ofs_stat_st_t;

endpackage
`default_nettype wire

// *** ofs_fifo_idx.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ofs_consts.svh"
module ofs_fifo_idx
  import ofs_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   soft_rst,
  input  wire logic                   push,
  input  wire logic                   pop,
  input  wire logic                   flush,
  input  wire logic                   rollover,
  input  wire logic                   rd_load,
  input  wire logic [`OFS_IDX_W-1:0]  rd_load_val,
  output logic      [`OFS_IDX_W-1:0]  wr_idx,
  output logic      [`OFS_IDX_W-1:0]  rd_idx,
  output logic      [`OFS_CNT_W-1:0]  fill_count,
  output logic      [`OFS_LOST_W-1:0] lost_count
);

  ofs_fifo_st_t st_r;
  ofs_fifo_st_t st_nxt;
  logic         full;
  logic         pop_ok;
  logic         drop;
  logic         overwrite;

  // ---------------------------------------------------------------------------
  // index and counter update
  // ---------------------------------------------------------------------------
  // a pop in the same cycle frees a slot, so a full fifo still takes the push
  always_comb
  begin
    full      = (st_r.fill == `OFS_FIFO_FULL);
    pop_ok    = pop && (st_r.fill != '0);
    drop      = push && full && !pop_ok;
    overwrite = drop && rollover;
    st_nxt    = st_r;
    if (push && (!full || pop_ok || rollover))
      st_nxt.wr_idx = st_r.wr_idx + 8'h01;
    if (pop_ok || overwrite)
      st_nxt.rd_idx = st_r.rd_idx + 8'h01;
    if (push && !full && !pop_ok)
      st_nxt.fill = st_r.fill + 9'h001;
    else if (pop_ok && !push)
      st_nxt.fill = st_r.fill - 9'h001;
    if (drop && st_r.lost != `OFS_LOST_MAX)
      st_nxt.lost = st_r.lost + 7'h01;
    // host rewrite: fill follows the distance, so a rewrite can refetch old samples
    if (rd_load)
    begin
      st_nxt.rd_idx = rd_load_val;
      st_nxt.fill   = {1'b0, st_nxt.wr_idx - rd_load_val};
    end
    if (flush)
    begin
      st_nxt.wr_idx = '0;
      st_nxt.rd_idx = '0;
      st_nxt.fill   = '0;
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || soft_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign wr_idx     = st_r.wr_idx;
  assign rd_idx     = st_r.rd_idx;
  assign fill_count = st_r.fill;
  assign lost_count = st_r.lost;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || soft_rst);

  property p_push_adv;
    push && !full && !pop && !flush && !rd_load |=>
      wr_idx == $past(wr_idx) + 8'h01 && fill_count == $past(fill_count) + 9'h001;
  endproperty
  a_push_adv: assert property (p_push_adv) else $error("push did not advance index");

  property p_pop_adv;
    pop && fill_count != '0 && !push && !flush && !rd_load |=>
      rd_idx == $past(rd_idx) + 8'h01 && fill_count == $past(fill_count) - 9'h001;
  endproperty
  a_pop_adv: assert property (p_pop_adv) else $error("pop did not advance index");

  property p_rd_load;
    rd_load && !flush |=> rd_idx == $past(rd_load_val);
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("read index write lost");

  property p_lost_sat;
    lost_count == `OFS_LOST_MAX |=> lost_count == `OFS_LOST_MAX;
  endproperty
  a_lost_sat: assert property (p_lost_sat) else $error("lost count wrapped");

  property p_lost_inc;
    push && full && !pop && lost_count != `OFS_LOST_MAX |=>
      lost_count == $past(lost_count) + 7'h01;
  endproperty
  a_lost_inc: assert property (p_lost_inc) else $error("lost sample not counted");

  // a push and a pop on a full fifo swap one sample, so the count must not move
  property p_full_swap;
    push && pop && full && !flush && !rd_load |=> fill_count == $past(fill_count);
  endproperty
  a_full_swap: assert property (p_full_swap) else $error("fill moved on full swap");

  c_overrun:  cover property (push && full && rollover);
  c_rd_load:  cover property (rd_load ##1 pop);

endmodule
`default_nettype wire

// *** ofs_status_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ofs_consts.svh"
module ofs_status_regs
  import ofs_pkg::*;
#(
  parameter int MEAS_W           = 8,
  parameter int OOR_DELAY_CYCLES = `OFS_OOR_DELAY_MS * `OFS_CLK_KHZ
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  soft_rst,
  input  wire logic                  shutdown_request,
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_rd,
  input  wire logic                  reg_wr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  exp_valid,
  input  wire logic [`OFS_ADC_W-1:0] exp_result,
  input  wire logic                  pd_forward_bias,
  input  wire logic                  meas_a_valid,
  input  wire logic [MEAS_W-1:0]     limit_a_source,
  input  wire logic [MEAS_W-1:0]     limit_a_high,
  input  wire logic [MEAS_W-1:0]     limit_a_low,
  input  wire logic                  meas_b_valid,
  input  wire logic [MEAS_W-1:0]     limit_b_source,
  input  wire logic [MEAS_W-1:0]     limit_b_high,
  input  wire logic [MEAS_W-1:0]     limit_b_low,
  input  wire logic                  exposure_end,
  input  wire logic [8:0]            led_compliance_ok,
  input  wire logic                  supply_out_of_range,
  input  wire logic [6:0]            frame_divider_high,
  input  wire logic [7:0]            frame_divider_low,
  input  wire logic [14:0]           frame_period_needed,
  input  wire logic                  fifo_push,
  input  wire logic                  fifo_pop,
  input  wire logic                  fifo_flush,
  input  wire logic                  fifo_rollover,
  input  wire logic                  irq_src_a,
  input  wire logic                  irq_src_b,
  output logic                       irq_out_a,
  output logic                       irq_out_b,
  output logic [`OFS_IDX_W-1:0]      fifo_write_index,
  output logic [`OFS_IDX_W-1:0]      fifo_read_index
);

  localparam logic [`OFS_OOR_CNT_W-1:0] OOR_LAST =
    `OFS_OOR_CNT_W'(OOR_DELAY_CYCLES - 1);

  ofs_stat_st_t              st_r;
  ofs_stat_st_t              st_nxt;
  logic [`OFS_IDX_W-1:0]     wr_idx;
  logic [`OFS_IDX_W-1:0]     rd_idx;
  logic [`OFS_CNT_W-1:0]     fill;
  logic [`OFS_LOST_W-1:0]    lost;
  logic                      rd_s1;
  logic                      rd_s2;
  logic                      rd_s3;
  logic                      set_exp;
  logic                      set_lim_a;
  logic                      set_lim_b;
  logic [8:0]                set_led;
  logic                      set_oor;
  logic                      set_inv;

  // unsigned range test, strict at both limits, shared by both limit checks
  function automatic logic outside(input logic [MEAS_W-1:0] v,
                                   input logic [MEAS_W-1:0] hi,
                                   input logic [MEAS_W-1:0] lo);
    outside = (v > hi) || (v < lo);
  endfunction

  function automatic logic rd_hit(input logic [7:0] a, input logic [7:0] ofs);
    rd_hit = reg_rd && (a == ofs);
  endfunction

  // ---------------------------------------------------------------------------
  // fifo indices and counters
  // ---------------------------------------------------------------------------
  ofs_fifo_idx u_fifo_idx (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .soft_rst    (soft_rst),
    .push        (fifo_push),
    .pop         (fifo_pop),
    .flush       (fifo_flush),
    .rollover    (fifo_rollover),
    .rd_load     (reg_wr && reg_addr == `OFS_ADDR_READ_INDEX),
    .rd_load_val (reg_wdata),
    .wr_idx      (wr_idx),
    .rd_idx      (rd_idx),
    .fill_count  (fill),
    .lost_count  (lost)
  );

  // ---------------------------------------------------------------------------
  // hardware set events
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rd_s1     = rd_hit(reg_addr, `OFS_ADDR_STATUS_FIRST);
    rd_s2     = rd_hit(reg_addr, `OFS_ADDR_STATUS_SECOND);
    rd_s3     = rd_hit(reg_addr, `OFS_ADDR_STATUS_LED);
    set_exp   = pd_forward_bias
              || (exp_valid && (exp_result == `OFS_ADC_POS_FULL
                  || $signed(exp_result) < $signed(`OFS_ADC_NEG_QUARTER)));
    set_lim_a = meas_a_valid
              && outside(limit_a_source, limit_a_high, limit_a_low);
    set_lim_b = meas_b_valid
              && outside(limit_b_source, limit_b_high, limit_b_low);
    set_led   = exposure_end ? ~led_compliance_ok : 9'h000;
    set_oor   = supply_out_of_range && (st_r.oor_cnt == OOR_LAST);
    set_inv   = {frame_divider_high, frame_divider_low} < frame_period_needed;
  end

  // ---------------------------------------------------------------------------
  // flag update: set beats clear in the same cycle
  // ---------------------------------------------------------------------------
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.exposure_overflow_flag = set_exp   || (st_r.exposure_overflow_flag && !rd_s1);
    st_nxt.lim_a   = set_lim_a || (st_r.lim_a && !rd_s1);
    st_nxt.lim_b   = set_lim_b || (st_r.lim_b && !rd_s1);
    // power flag only sets at reset, so here it can only be cleared
    st_nxt.pwr     = st_r.pwr && !rd_s1 && !shutdown_request;
    st_nxt.led_low[`OFS_LED9_IDX] = set_led[`OFS_LED9_IDX]
                   || (st_r.led_low[`OFS_LED9_IDX] && !rd_s2);
    st_nxt.led_low[7:0] = set_led[7:0] | (st_r.led_low[7:0] & {8{!rd_s3}});
    st_nxt.oor     = set_oor || (st_r.oor && !rd_s2);
    st_nxt.inv_cfg = set_inv || (st_r.inv_cfg && !rd_s2);
    // delay restarts on each expiry, so a lasting fault keeps retriggering
    if (!supply_out_of_range || set_oor)
      st_nxt.oor_cnt = '0;
    else
      st_nxt.oor_cnt = st_r.oor_cnt + `OFS_OOR_CNT_W'(1);
    st_nxt.irq_a   = st_nxt.pwr || irq_src_a;
    st_nxt.irq_b   = st_nxt.pwr || irq_src_b;
    // read data shows the state before the read's own clear
    if (reg_rd)
    begin
      unique case (reg_addr)
        `OFS_ADDR_STATUS_FIRST:
          st_nxt.rdata = {4'h0, st_r.exposure_overflow_flag, st_r.lim_b, st_r.lim_a, st_r.pwr};
        `OFS_ADDR_STATUS_SECOND:
          st_nxt.rdata = {st_r.led_low[`OFS_LED9_IDX], st_r.oor, 3'h0,
                          st_r.inv_cfg, 2'h0};
        `OFS_ADDR_STATUS_LED:   st_nxt.rdata = st_r.led_low[7:0];
        `OFS_ADDR_WRITE_INDEX:  st_nxt.rdata = wr_idx;
        `OFS_ADDR_READ_INDEX:   st_nxt.rdata = rd_idx;
        `OFS_ADDR_COUNT_LOSS:   st_nxt.rdata = {fill[8], lost};
        `OFS_ADDR_COUNT_LOW:    st_nxt.rdata = fill[7:0];
        default:                st_nxt.rdata = `OFS_RESET_BYTE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  // soft reset restores everything but never raises the power flag
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r       <= '0;
      st_r.pwr   <= `OFS_RESET_PWR;
      st_r.irq_a <= `OFS_RESET_PWR;
      st_r.irq_b <= `OFS_RESET_PWR;
    end
    else if (soft_rst)
    begin
      st_r       <= '0;
      st_r.pwr   <= st_r.pwr;
      st_r.irq_a <= st_r.pwr;
      st_r.irq_b <= st_r.pwr;
    end
    else
      st_r <= st_nxt;
  end

  assign reg_rdata        = st_r.rdata;
  assign irq_out_a        = st_r.irq_a;
  assign irq_out_b        = st_r.irq_b;
  assign fifo_write_index = wr_idx;
  assign fifo_read_index  = rd_idx;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || soft_rst);

  property p_exp_over;
    exp_valid && exp_result == `OFS_ADC_POS_FULL |=> st_r.exposure_overflow_flag;
  endproperty
  a_exp_over: assert property (p_exp_over) else $error("overrange not flagged");

  property p_exp_under;
    exp_valid && $signed(exp_result) < $signed(`OFS_ADC_NEG_QUARTER) |=> st_r.exposure_overflow_flag;
  endproperty
  a_exp_under: assert property (p_exp_under) else $error("underrange not flagged");

  property p_fwd_bias;
    pd_forward_bias && rd_s1 |=> st_r.exposure_overflow_flag;
  endproperty
  a_fwd_bias: assert property (p_fwd_bias) else $error("forward bias lost on read");

  property p_lim_a;
    meas_a_valid && limit_a_source < limit_a_low |=> st_r.lim_a;
  endproperty
  a_lim_a: assert property (p_lim_a) else $error("limit a low crossing missed");

  property p_lim_b;
    !meas_b_valid && rd_s1 |=> !st_r.lim_b;
  endproperty
  a_lim_b: assert property (p_lim_b) else $error("limit b not cleared by read");

  property p_pwr_irq;
    st_r.pwr |-> irq_out_a && irq_out_b;
  endproperty
  a_pwr_irq: assert property (p_pwr_irq) else $error("power event not on both irqs");

  property p_pwr_clr;
    st_r.pwr && shutdown_request |=> !st_r.pwr ##1 !st_r.pwr;
  endproperty
  a_pwr_clr: assert property (p_pwr_clr) else $error("shutdown left power flag");

  property p_led;
    exposure_end && !led_compliance_ok[0] ##1 rd_s3 |=> reg_rdata[0] && !st_r.led_low[0];
  endproperty
  a_led: assert property (p_led) else $error("compliance flag read wrong");

  property p_oor;
    supply_out_of_range && st_r.oor_cnt == OOR_LAST |=> st_r.oor && st_r.oor_cnt == '0;
  endproperty
  a_oor: assert property (p_oor) else $error("supply delay expiry missed");

  property p_inv;
    set_inv && rd_s2 |=> st_r.inv_cfg;
  endproperty
  a_inv: assert property (p_inv) else $error("invalid config lost on read");

  property p_cnt_reg;
    reg_rd && reg_addr == `OFS_ADDR_COUNT_LOSS |=> reg_rdata == {$past(fill[8]), $past(lost)};
  endproperty
  a_cnt_reg: assert property (p_cnt_reg) else $error("count register mismatch");

  c_oor:     cover property (st_r.oor ##1 rd_s2 ##1 !st_r.oor);
  c_set_clr: cover property (set_lim_a && rd_s1);
  c_led9:    cover property (rd_s2 && st_r.led_low[`OFS_LED9_IDX]);

endmodule
`default_nettype wire

// *** ofs_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ofs_host_model
(
  input  wire logic       ref_clk,
  output logic      [7:0] reg_addr,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // bus idle at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
  end

  // one-cycle write; a read index write also reloads the fill count
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d; // released lines never show the stale value
    reg_addr  = ~a;
  endtask

  // one-cycle read; data is registered one edge after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule
`default_nettype wire

// *** test_ofs_status_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_ofs_status_regs;
  logic        ref_clk = 1'b0, rst_n = 1'b0, soft_rst = 1'b0, shutdown_request = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic        reg_rd, reg_wr, exp_valid = 1'b0, pd_forward_bias = 1'b0;
  logic [19:0] exp_result = 20'h00000;
  logic        meas_a_valid = 1'b0, meas_b_valid = 1'b0, exposure_end = 1'b0;
  logic [7:0]  limit_a_source = 8'h00, limit_a_high = 8'h80, limit_a_low = 8'h20;
  logic [7:0]  limit_b_source = 8'h00, limit_b_high = 8'h80, limit_b_low = 8'h20;
  logic [8:0]  led_compliance_ok = 9'h1FF;
  logic        supply_out_of_range = 1'b0, fifo_push = 1'b0, fifo_pop = 1'b0;
  logic [6:0]  frame_divider_high = 7'h00;
  logic [7:0]  frame_divider_low = 8'hFF;
  logic [14:0] frame_period_needed = 15'h0000;
  logic        fifo_flush = 1'b0, fifo_rollover = 1'b0, irq_src_a = 1'b0, irq_src_b = 1'b0;
  logic        irq_out_a, irq_out_b;
  logic [7:0]  fifo_write_index, fifo_read_index;
  int          err_total = 0, checks = 0, cyc = 0;
  logic [19:0] ev [4] = '{20'h7FFFF, 20'h7FFFE, 20'hDFFFF, 20'hE0000};
  logic [7:0]  sv [4] = '{8'h81, 8'h80, 8'h1F, 8'h20};
  logic [7:0]  ra [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};

  always #2.5 ref_clk = ~ref_clk;

  ofs_status_regs #(.MEAS_W(8), .OOR_DELAY_CYCLES(8)) i_ofs_status_regs (.ref_clk, .rst_n,
    .soft_rst, .shutdown_request, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
    .exp_valid, .exp_result, .pd_forward_bias, .meas_a_valid, .limit_a_source, .limit_a_high,
    .limit_a_low, .meas_b_valid, .limit_b_source, .limit_b_high, .limit_b_low, .exposure_end,
    .led_compliance_ok, .supply_out_of_range, .frame_divider_high, .frame_divider_low,
    .frame_period_needed, .fifo_push, .fifo_pop, .fifo_flush, .fifo_rollover, .irq_src_a,
    .irq_src_b, .irq_out_a, .irq_out_b, .fifo_write_index, .fifo_read_index);

  ofs_host_model i_ofs_host_model (.ref_clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata);

  task automatic report_and_stop();
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_ofs_host_model.rd_reg(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask

  // reset pulse of three cycles, synchronous
  task automatic do_rst();
    rst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
  endtask

  // one-cycle pulse of the soft reset or the shutdown level
  task automatic pulse_ctl(input bit sd);
    @(negedge ref_clk);
    if (sd)
      shutdown_request = 1'b1;
    else
      soft_rst = 1'b1;
    @(negedge ref_clk);
    shutdown_request = 1'b0;
    soft_rst = 1'b0;
  endtask

  // hang guard: whole run is well under two thousand cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    do_rst();
    chk("irq_out_a", 8'h01, {7'h00, irq_out_a});
    chk("irq_out_b", 8'h01, {7'h00, irq_out_b});
    for (int i = 0; i < 6; i++) rchk(ra[i], 8'h00);
    rchk(8'h00, 8'h01);
    rchk(8'h00, 8'h00);
    chk("irq_out_a", 8'h00, {7'h00, irq_out_a});
    irq_src_a = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("irq_pair", 8'h02, {6'h00, irq_out_a, irq_out_b});
    irq_src_a = 1'b0;
    // power flag: soft reset keeps it, shutdown clears it, soft reset never sets it
    do_rst();
    pulse_ctl(1'b0);
    rchk(8'h00, 8'h01);
    do_rst();
    pulse_ctl(1'b1);
    rchk(8'h00, 8'h00);
    pulse_ctl(1'b0);
    rchk(8'h00, 8'h00);
    // exposure range boundaries
    for (int i = 0; i < 4; i++)
    begin
      @(negedge ref_clk);
      exp_result = ev[i];
      exp_valid = 1'b1;
      @(negedge ref_clk);
      exp_valid = 1'b0;
      rchk(8'h00, {4'h0, ~i[0], 3'h0});
    end
    // forward bias held across the clearing read must survive it
    @(negedge ref_clk);
    pd_forward_bias = 1'b1;
    i_ofs_host_model.rd_reg(8'h00, d);
    pd_forward_bias = 1'b0;
    chk("status1", 8'h08, d);
    rchk(8'h00, 8'h08);
    rchk(8'h00, 8'h00);
    // limit crossings: above, at high, below, at low
    for (int i = 0; i < 4; i++)
    begin
      @(negedge ref_clk);
      limit_a_source = sv[i];
      limit_b_source = sv[i];
      meas_a_valid = 1'b1;
      meas_b_valid = 1'b1;
      @(negedge ref_clk);
      meas_a_valid = 1'b0;
      meas_b_valid = 1'b0;
      rchk(8'h00, {5'h00, ~i[0], ~i[0], 1'b0});
    end
    @(negedge ref_clk);
    limit_a_source = 8'hFF;
    meas_a_valid = 1'b1;
    @(negedge ref_clk);
    meas_a_valid = 1'b0;
    rchk(8'h00, 8'h02);
    // led compliance: alternate drivers low, led nine included
    @(negedge ref_clk);
    led_compliance_ok = 9'h0AA;
    exposure_end = 1'b1;
    @(negedge ref_clk);
    exposure_end = 1'b0;
    led_compliance_ok = 9'h1FF;
    rchk(8'h02, 8'h55);
    rchk(8'h01, 8'h80);
    rchk(8'h02, 8'h00);
    // supply out of range sets after the delay and retriggers
    supply_out_of_range = 1'b1;
    rchk(8'h01, 8'h00);
    repeat (8) @(negedge ref_clk);
    rchk(8'h01, 8'h40);
    repeat (8) @(negedge ref_clk);
    rchk(8'h01, 8'h40);
    supply_out_of_range = 1'b0;
    i_ofs_host_model.rd_reg(8'h01, d);
    rchk(8'h01, 8'h00);
    // frame period shorter than needed
    frame_period_needed = 15'h0100;
    repeat (2) @(negedge ref_clk);
    frame_period_needed = 15'h0000;
    rchk(8'h01, 8'h04);
    rchk(8'h01, 8'h00);
    // fifo indices and counts
    fifo_push = 1'b1;
    repeat (3) @(negedge ref_clk);
    fifo_push = 1'b0;
    fifo_pop = 1'b1;
    @(negedge ref_clk);
    fifo_pop = 1'b0;
    chk("fifo_write_index", 8'h03, fifo_write_index);
    chk("fifo_read_index", 8'h01, fifo_read_index);
    rchk(8'h07, 8'h02);
    i_ofs_host_model.wr_reg(8'h05, 8'h00);
    i_ofs_host_model.wr_reg(8'h04, 8'h55);
    rchk(8'h05, 8'h00);
    rchk(8'h07, 8'h03);
    rchk(8'h04, 8'h03);
    fifo_flush = 1'b1;
    @(negedge ref_clk);
    fifo_flush = 1'b0;
    fifo_pop = 1'b1;
    @(negedge ref_clk);
    fifo_pop = 1'b0;
    chk("fifo_read_index", 8'h00, fifo_read_index);
    fifo_push = 1'b1;
    repeat (256) @(negedge ref_clk);
    fifo_push = 1'b0;
    rchk(8'h06, 8'h80);
    rchk(8'h07, 8'h00);
    fifo_push = 1'b1;
    repeat (130) @(negedge ref_clk);
    fifo_push = 1'b0;
    rchk(8'h06, 8'hFF);
    chk("fifo_write_index", 8'h00, fifo_write_index);
    fifo_rollover = 1'b1;
    fifo_push = 1'b1;
    @(negedge ref_clk);
    fifo_push = 1'b0;
    chk("index_pair_lsb", 8'h11, {3'h0, fifo_write_index[0], 3'h0, fifo_read_index[0]});
    // push and pop together on a full fifo: count stays at 256
    fifo_pop = 1'b1;
    fifo_push = 1'b1;
    @(negedge ref_clk);
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    rchk(8'h06, 8'hFF);
    report_and_stop();
  end
endmodule
`default_nettype wire
